// >>> core/fsr_pkg.sv
// fsr_pkg: constants and carriers for the volatile status register one block
// assumes: opcodes arrive over a serial link, array engines report on core clock
package fsr_pkg;
  localparam logic [7:0] FSR_OPC_SET_WEL  = 8'h06;
  localparam logic [7:0] FSR_OPC_CLR_WEL  = 8'h04;
  localparam logic [7:0] FSR_OPC_CLR_ST_A = 8'h30;
  localparam logic [7:0] FSR_OPC_CLR_ST_B = 8'h82;
  localparam logic [7:0] FSR_OPC_RD_ANY   = 8'h65;
  localparam logic [7:0] FSR_OPC_WR_ANY   = 8'h71;
  localparam logic [7:0] FSR_OPC_RD_ST1   = 8'h05;
  localparam logic [7:0] FSR_OPC_WR_REGS  = 8'h01;
  localparam logic [7:0] FSR_OPC_PROG     = 8'h02;
  localparam logic [7:0] FSR_OPC_ERASE    = 8'hD8;
  localparam logic [7:0] FSR_OPC_BULK     = 8'h60;
  localparam logic [7:0] FSR_OPC_ERS_SUSP = 8'h75;
  localparam logic [7:0] FSR_OPC_PGM_SUSP = 8'h85;
  localparam logic [7:0] FSR_OPC_SW_RST   = 8'hF0;

  localparam int FSR_BIT_LOCK = 7;
  localparam int FSR_BIT_PERR = 6;
  localparam int FSR_BIT_EERR = 5;
  localparam int FSR_BP_HI    = 4;
  localparam int FSR_BP_LO    = 2;
  localparam int FSR_BIT_WEL  = 1;
  localparam int FSR_BIT_WIP  = 0;

  localparam logic [7:0] FSR_STATUS_RST = 8'h00;
  localparam logic [2:0] FSR_BP_NONE    = 3'h0;
  localparam logic [3:0] FSR_LAST_BIT   = 4'h7;
  localparam logic [4:0] FSR_SYNC_RST   = 5'h18;

  typedef enum logic [2:0] {
    FSR_OP_IDLE,
    FSR_OP_PROG,
    FSR_OP_ERASE,
    FSR_OP_BULK,
    FSR_OP_NVWR
  } fsr_op_e;

  typedef struct packed {
    logic       lock;
    logic [2:0] bp;
    logic       wel_default;
    logic       bp_volatile;
  } fsr_nv_s;

  typedef struct packed {
    logic done;
    logic fail;
    logic prot_hit;
    logic parked;
  } fsr_eng_s;

  typedef struct packed {
    logic       start;
    logic       suspend;
    fsr_op_e    kind;
    logic [2:0] bp_data;
  } fsr_req_s;

  function automatic logic fsr_is_clr(input logic [7:0] c);
    return (c == FSR_OPC_CLR_ST_A) || (c == FSR_OPC_CLR_ST_B);
  endfunction

  function automatic logic fsr_is_read(input logic [7:0] c);
    return (c == FSR_OPC_RD_ST1) || (c == FSR_OPC_RD_ANY);
  endfunction
endpackage

// >>> core/fsr_sync.sv
// fsr_sync: two-stage synchroniser for independent level or toggle bits
// assumes: each bit is a level or toggle, never a multi-bit word
`timescale 1ns/1ps
`default_nettype none
module fsr_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // fsr_sync
`default_nettype wire

// >>> core/fsr_status1_top.sv
// fsr_status1_top: volatile status register one with command gating
// assumes: serial host on SCK/CS_N/SI/SO, engines and nv bits on CORE_CLK
// What this block does
// R1: lock copy bit follows the non-volatile lock bit.
// R2: program failure or protected/locked target sets program error.
// R3: either clear-status opcode clears both error flags.
// R4: erase failure or protected sector sets erase error.
// R5: bulk erase hitting a protected sector does not set erase error.
// R6: error flags ignore register-write commands.
// R7: non-volatile mode: register write programs nv bits, volatile copy follows.
// R8: volatile mode: register write sets only the volatile protection field.
// R9: any protection bit set refuses program/erase in that area.
// R10: bulk erase runs only with all protection bits zero.
// R11: writes, program and erase need the write latch set.
// R12: set-latch opcode sets the latch, clear-latch opcode clears it.
// R13: successful program, write or erase clears the latch.
// R14: host clears a latch left set after failure: clear status, then clear latch.
// R15: resets load the write latch from its non-volatile default bit.
// R16: a register write clears the write latch once it completes.
// R17: while busy only reads, suspends, clear status and soft reset pass.
// R18: suspends only accepted while a matching array operation runs.
// R19: an error flag holds busy until clear status.
// R20: busy is low only with no operation; read-only.
// R21: write latch reset value comes from its non-volatile default bit.
// R22: nv lock with write-protect pin low blocks register writes.
// R23: register is shifted out most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module fsr_status1_top
  import fsr_pkg::*;
(
  input  wire logic     CORE_CLK,
  input  wire logic     SYS_RST,
  input  wire logic     SCK,
  input  wire logic     CS_N,
  input  wire logic     SI,
  output logic          SO,
  output logic          SO_OE_N,
  input  wire logic     WP_N,
  input  wire fsr_nv_s  NV_BITS,
  input  wire fsr_eng_s ENG_STAT,
  output fsr_req_s      ENG_REQ,
  output logic [2:0]    PROT_LEVEL
);
  // link side
  logic       frame_clr;
  logic [3:0] bit_cnt;
  logic       got_cmd;
  logic       got_dat;
  logic [6:0] shift_in;
  logic [7:0] cmd_byte;
  logic [7:0] dat_byte;
  logic       cmd_tgl;
  logic       dat_tgl;
  logic [7:0] shadow;
  logic       ack_tgl;
  logic       req_sck;
  logic [7:0] out_sh;
  logic       drive;
  // core side
  logic [4:0] sync_out;
  logic       cs_d;
  logic       end_p;
  logic       cmd_seen;
  logic       dat_seen;
  logic       have_cmd;
  logic       have_dat;
  logic       lock_copy;
  logic       perr;
  logic       eerr;
  logic [2:0] bp_v;
  logic       write_enable_latch;
  fsr_op_e    state;
  fsr_op_e    next_state;
  fsr_req_s   req;
  logic [7:0] status;
  logic [7:0] snap;
  logic       snap_req;

  wire       byte_done = (bit_cnt == FSR_LAST_BIT);
  wire [7:0] rx_byte   = {shift_in, SI};
  wire       rd_cmd    = fsr_is_read(cmd_byte);

  // counter restarts with every frame, the link clock may stop between frames
  assign frame_clr = SYS_RST | CS_N;

  always_ff @(posedge SCK or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      bit_cnt  <= 4'h0;
      got_cmd  <= 1'h0;
      got_dat  <= 1'h0;
      shift_in <= 7'h00;
    end
    else
    begin
      bit_cnt  <= byte_done ? 4'h0 : bit_cnt + 4'h1;
      shift_in <= rx_byte[6:0];
      if (byte_done)
      begin
        got_cmd <= 1'h1;
        got_dat <= got_cmd;
      end
    end
  end

  // bytes stay put after the frame, core reads them only once CS_N is high
  always_ff @(posedge SCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cmd_byte <= 8'h00;
      dat_byte <= 8'h00;
      cmd_tgl  <= 1'h0;
      dat_tgl  <= 1'h0;
    end
    else if (byte_done && !got_cmd)
    begin
      cmd_byte <= rx_byte;
      cmd_tgl  <= ~cmd_tgl;
    end
    else if (byte_done && !got_dat)
    begin
      dat_byte <= rx_byte;
      dat_tgl  <= ~dat_tgl;
    end
  end

  fsr_sync #(.W(1), .RST_VAL(1'h0)) u_req_sync (
    .clk (SCK),
    .rst (SYS_RST),
    .d   (snap_req),
    .q   (req_sck)
  );

  // toggle handshake: snap is frozen while the request is outstanding
  always_ff @(posedge SCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      shadow  <= FSR_STATUS_RST;
      ack_tgl <= 1'h0;
    end
    else if (req_sck != ack_tgl)
    begin
      shadow  <= snap;
      ack_tgl <= req_sck;
    end
  end

  // repeats the byte for as long as the host keeps clocking
  always_ff @(negedge SCK or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      out_sh <= 8'h00;
      drive  <= 1'h0;
    end
    else
    begin
      drive  <= got_cmd & rd_cmd;
      out_sh <= (got_cmd && bit_cnt == 4'h0) ? shadow : {out_sh[6:0], 1'h0}; // R23
    end
  end

  assign SO      = out_sh[7]; // R23
  assign SO_OE_N = ~drive;

  fsr_sync #(.W(5), .RST_VAL(FSR_SYNC_RST)) u_core_sync (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .d   ({CS_N, WP_N, cmd_tgl, dat_tgl, ack_tgl}),
    .q   (sync_out)
  );

  wire cs_q  = sync_out[4];
  wire wp_q  = sync_out[3];
  wire cmd_q = sync_out[2];
  wire dat_q = sync_out[1];
  wire ack_q = sync_out[0];

  // one spare cycle after the CS edge lets late toggles land first
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      cs_d     <= 1'h1;
      end_p    <= 1'h0;
      cmd_seen <= 1'h0;
      dat_seen <= 1'h0;
      have_cmd <= 1'h0;
      have_dat <= 1'h0;
    end
    else
    begin
      cs_d     <= cs_q;
      end_p    <= cs_q & ~cs_d;
      cmd_seen <= cmd_q;
      dat_seen <= dat_q;
      have_cmd <= (cmd_q != cmd_seen) | (have_cmd & ~end_p);
      have_dat <= (dat_q != dat_seen) | (have_dat & ~end_p);
    end
  end

  wire go      = end_p & have_cmd;
  wire op_run  = (state != FSR_OP_IDLE);
  wire write_in_progress     = op_run | perr | eerr; // R19 R20
  wire lock    = NV_BITS.lock & ~wp_q; // R22
  wire c_set_write_latch_cmd  = (cmd_byte == FSR_OPC_SET_WEL);
  wire c_clear_write_latch_cmd  = (cmd_byte == FSR_OPC_CLR_WEL);
  wire c_clear_status_cmd  = fsr_is_clr(cmd_byte);
  wire c_wrr   = (cmd_byte == FSR_OPC_WR_REGS) | (cmd_byte == FSR_OPC_WR_ANY);
  wire c_prog  = (cmd_byte == FSR_OPC_PROG);
  wire c_sers  = (cmd_byte == FSR_OPC_ERASE);
  wire c_bulk  = (cmd_byte == FSR_OPC_BULK);
  wire c_esus  = (cmd_byte == FSR_OPC_ERS_SUSP);
  wire c_psus  = (cmd_byte == FSR_OPC_PGM_SUSP);
  wire c_rst   = (cmd_byte == FSR_OPC_SW_RST);
  wire may_wr  = go & write_enable_latch & ~write_in_progress; // R11 R17

  wire acc_set_write_latch_cmd = go & c_set_write_latch_cmd & ~write_in_progress; // R12 R17
  wire acc_clear_write_latch_cmd = go & c_clear_write_latch_cmd & ~write_in_progress; // R12 R17
  wire acc_clear_status_cmd = go & c_clear_status_cmd; // R3
  wire acc_rst  = go & c_rst;
  wire acc_wreg = may_wr & c_wrr & have_dat & ~lock; // R22
  wire acc_prog = may_wr & c_prog;
  wire acc_sers = may_wr & c_sers;
  wire acc_bulk = may_wr & c_bulk & (bp_v == FSR_BP_NONE); // R10
  wire acc_esus = go & c_esus & ((state == FSR_OP_ERASE) | (state == FSR_OP_BULK)); // R18
  wire acc_psus = go & c_psus & (state == FSR_OP_PROG); // R18
  wire nv_wr    = acc_wreg & ~NV_BITS.bp_volatile; // R7
  wire wreg_vol = acc_wreg & NV_BITS.bp_volatile; // R8
  wire do_start = acc_prog | acc_sers | acc_bulk | nv_wr;

  wire eng_end  = ENG_STAT.done & op_run;
  wire eng_park = ENG_STAT.parked & op_run;
  // bulk erase steps over protected sectors without failing
  wire eng_bad  = ENG_STAT.fail | (ENG_STAT.prot_hit & (state != FSR_OP_BULK)); // R5
  // a failed end leaves the latch set for the host to clear
  wire ok_end   = eng_end & ~eng_bad; // R13 R14
  wire set_perr = eng_end & (state == FSR_OP_PROG) & eng_bad; // R2
  wire set_eerr = eng_end & (((state == FSR_OP_ERASE) & eng_bad) // R4
                  | ((state == FSR_OP_BULK) & ENG_STAT.fail)); // R5

  wire       next_wel = acc_set_write_latch_cmd | (write_enable_latch & ~(acc_clear_write_latch_cmd | ok_end | wreg_vol)); // R12 R13 R16
  wire [2:0] next_bp  = NV_BITS.bp_volatile
                        ? (wreg_vol ? dat_byte[FSR_BP_HI:FSR_BP_LO] : bp_v) // R8
                        : NV_BITS.bp; // R7

  always_comb
  begin
    next_state = state;
    case (state)
      FSR_OP_IDLE:
        if (acc_prog)
          next_state = FSR_OP_PROG;
        else if (acc_sers)
          next_state = FSR_OP_ERASE;
        else if (acc_bulk)
          next_state = FSR_OP_BULK;
        else if (nv_wr)
          next_state = FSR_OP_NVWR;
      FSR_OP_PROG, FSR_OP_ERASE, FSR_OP_BULK, FSR_OP_NVWR:
        if (eng_end | eng_park)
          next_state = FSR_OP_IDLE;
      default:
        next_state = FSR_OP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST | acc_rst)
      state <= FSR_OP_IDLE;
    else
      state <= next_state;
  end

  // set beats a clear arriving in the same cycle
  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST | acc_rst)
    begin
      perr <= 1'h0;
      eerr <= 1'h0;
    end
    else
    begin
      perr <= set_perr | (perr & ~acc_clear_status_cmd); // R2 R3 R6
      eerr <= set_eerr | (eerr & ~acc_clear_status_cmd); // R3 R4 R6
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST | acc_rst)
      write_enable_latch <= NV_BITS.wel_default; // R15 R21
    else
      write_enable_latch <= next_wel;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      bp_v      <= NV_BITS.bp;
      lock_copy <= 1'h0;
    end
    else
    begin
      bp_v      <= next_bp;
      lock_copy <= NV_BITS.lock; // R1
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST | acc_rst)
      req <= '{start: 1'h0, suspend: 1'h0, kind: FSR_OP_IDLE, bp_data: FSR_BP_NONE};
    else
    begin
      req.start   <= do_start;
      req.suspend <= acc_esus | acc_psus; // R18
      if (do_start)
      begin
        req.kind    <= next_state;
        req.bp_data <= dat_byte[FSR_BP_HI:FSR_BP_LO]; // R7
      end
    end
  end

  assign ENG_REQ    = req;
  assign PROT_LEVEL = bp_v; // R9

  always_comb
  begin
    status                        = FSR_STATUS_RST;
    status[FSR_BIT_LOCK]          = lock_copy;
    status[FSR_BIT_PERR]          = perr;
    status[FSR_BIT_EERR]          = eerr;
    status[FSR_BP_HI:FSR_BP_LO]   = bp_v;
    status[FSR_BIT_WEL]           = write_enable_latch;
    status[FSR_BIT_WIP]           = write_in_progress; // R20
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SYS_RST)
    begin
      snap     <= FSR_STATUS_RST;
      snap_req <= 1'h0;
    end
    else if ((ack_q == snap_req) && (snap != status))
    begin
      snap     <= status;
      snap_req <= ~snap_req;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  property p_wel_set;
    acc_set_write_latch_cmd |=> write_enable_latch;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set"); // R12

  property p_wel_clr;
    acc_clear_write_latch_cmd |=> !write_enable_latch;
  endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch not cleared"); // R12

  property p_no_wel;
    go && (c_prog || c_sers || c_bulk) && !write_enable_latch |=> !ENG_REQ.start;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("start without latch"); // R11

  property p_bulk_prot;
    go && c_bulk && bp_v != FSR_BP_NONE |=> !ENG_REQ.start;
  endproperty
  a_bulk_prot: assert property (p_bulk_prot) else $error("bulk erase ran protected"); // R10

  property p_busy_ign;
    go && (c_set_write_latch_cmd || c_clear_write_latch_cmd) && write_in_progress && !ok_end |=> write_enable_latch == $past(write_enable_latch);
  endproperty
  a_busy_ign: assert property (p_busy_ign) else $error("latch changed when busy"); // R17

  property p_clear_status_cmd;
    acc_clear_status_cmd && !set_perr && !set_eerr && !op_run |=> !perr && !eerr && !write_in_progress;
  endproperty
  a_clear_status_cmd: assert property (p_clear_status_cmd) else $error("clear status ignored"); // R3

  property p_err_hold;
    perr && !acc_clear_status_cmd && !acc_rst |=> write_in_progress && perr;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("busy dropped on error"); // R19

  property p_done_wel;
    ok_end && !acc_rst |=> !write_enable_latch;
  endproperty
  a_done_wel: assert property (p_done_wel) else $error("latch kept after success"); // R13

  property p_bulk_err;
    eng_end && state == FSR_OP_BULK && !ENG_STAT.fail && !eerr |=> !eerr;
  endproperty
  a_bulk_err: assert property (p_bulk_err) else $error("bulk set erase error"); // R5

  property p_lock;
    go && c_wrr && lock && !write_in_progress |=> bp_v == $past(bp_v) && !ENG_REQ.start;
  endproperty
  a_lock: assert property (p_lock) else $error("write passed lock"); // R22

  property p_err_ro;
    acc_wreg && !perr && !set_perr |=> !perr;
  endproperty
  a_err_ro: assert property (p_err_ro) else $error("write hit error flag"); // R6

  property p_susp;
    go && ((c_psus && state != FSR_OP_PROG)
      || (c_esus && state != FSR_OP_ERASE && state != FSR_OP_BULK)) |=> !ENG_REQ.suspend;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend without matching operation"); // R18

  property p_copy;
    $changed(NV_BITS.lock) |=> lock_copy == $past(NV_BITS.lock);
  endproperty
  a_copy: assert property (p_copy) else $error("lock copy stale"); // R1

  c_prog_run: cover property (acc_prog ##1 ENG_REQ.start ##[1:50] ok_end);
  c_err_clr: cover property (set_perr ##[1:300] acc_clear_status_cmd);
  c_bulk_no: cover property (go && c_bulk && bp_v != FSR_BP_NONE);
  c_vol_wr: cover property (wreg_vol ##1 !write_enable_latch);
endmodule // fsr_status1_top
`default_nettype wire

// >>> testbench/fsr_host_model.sv
// fsr_host_model: serial host issuing one command per frame, reading back a byte
// assumes: mode 0 framing; caller keeps frames apart by the core-side gap
`timescale 1ns/1ps
`default_nettype none
module fsr_host_model (
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO,
  input  wire logic SO_OE_N
);
  initial
  begin
    SCK  = 1'b0;
    CS_N = 1'b1;
    SI   = 1'b0;
  end

  // link clock only runs inside a frame; 6 ns period
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, input bit n16,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, dat};
    rd = 'x;
    #7 CS_N = 1'b0;
    for (int i = 0; i < (n16 ? 16 : 8); i++)
    begin
      SI = sh[15 - i];
      #3 SCK = 1'b1;
      if (i > 7)
        rd[15 - i] = (SO_OE_N === 1'b0) ? SO : 1'bx;
      #3 SCK = 1'b0;
    end
    #3 CS_N = 1'b1;
    // released line shows the inverse, never a stale copy
    SI = ~SI;
  endtask
endmodule // fsr_host_model
`default_nettype wire

// >>> testbench/fsr_status1_top_test.sv
// fsr_status1_top_test: scripted commands against a reference model of status one
// assumes: host model on the link, bench engine model on the core side
`timescale 1ns/1ps
`default_nettype none
module fsr_status1_top_test
  import fsr_pkg::*;
;
  logic       CORE_CLK, SYS_RST, SCK, CS_N, SI, SO, SO_OE_N, WP_N, rd_any;
  fsr_nv_s    NV_BITS;
  fsr_eng_s   ENG_STAT;
  fsr_req_s   ENG_REQ;
  logic [2:0] PROT_LEVEL, m_bp, eng_bp;
  logic       m_perr, m_eerr, m_wel, eng_fail, eng_hit;
  logic [7:0] rd;
  logic [31:0] seed;
  fsr_op_e    eng_kind;
  int         n_mismatch, cmp_count, n_start, m_start, m_run, eng_lat, busy_cnt;
  logic [15:0] scr [$] = '{16'hFF0A, 16'h0200, 16'h0600, 16'h0400, 16'hFF01, 16'hFF00,
    16'h0600, 16'h011C, 16'h0600, 16'h6000, 16'h0200, 16'h0400, 16'h3000, 16'h0400,
    16'h0600, 16'h7100, 16'hFF01, 16'h0600, 16'h7108, 16'h0600, 16'h0100, 16'h0600,
    16'h0200, 16'h0600, 16'hD800, 16'hFF02,
    16'h0600, 16'hD800, 16'h8200, 16'h6000, 16'hFF03, 16'h0600, 16'h6000, 16'h3000,
    16'h0400, 16'hFF04, 16'hFF05, 16'h0600, 16'h0104, 16'hFF06, 16'h0104, 16'hFF07,
    16'h0600, 16'hFF08, 16'h0200, 16'h7500, 16'h0400, 16'h8500, 16'hFF09, 16'h0600,
    16'hF000, 16'h0600, 16'hFF0A};

  initial
  begin
    CORE_CLK = 1'b0;
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  fsr_status1_top u_fsr_status1_top (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .SCK(SCK),
    .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE_N(SO_OE_N), .WP_N(WP_N), .NV_BITS(NV_BITS),
    .ENG_STAT(ENG_STAT), .ENG_REQ(ENG_REQ), .PROT_LEVEL(PROT_LEVEL));
  fsr_host_model u_fsr_host_model (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO),
    .SO_OE_N(SO_OE_N));

  // array engine: refuses protected areas, slow latency lets suspends land
  always @(posedge CORE_CLK)
  begin
    ENG_STAT <= '0;
    if (SYS_RST)
      busy_cnt <= 0;
    else if (ENG_REQ.start === 1'b1)
    begin
      busy_cnt <= eng_lat;
      eng_kind <= ENG_REQ.kind;
      eng_bp   <= ENG_REQ.bp_data;
      n_start  <= n_start + 1;
    end
    else if (ENG_REQ.suspend === 1'b1 && busy_cnt > 0)
    begin
      busy_cnt        <= 0;
      ENG_STAT.parked <= 1'b1;
    end
    else if (busy_cnt == 1)
    begin
      busy_cnt          <= 0;
      ENG_STAT.done     <= 1'b1;
      ENG_STAT.fail     <= eng_fail;
      ENG_STAT.prot_hit <= eng_hit || (eng_kind != FSR_OP_NVWR && PROT_LEVEL != 3'h0);
      if (eng_kind == FSR_OP_NVWR)
        NV_BITS.bp <= eng_bp;
    end
    else if (busy_cnt > 1)
      busy_cnt <= busy_cnt - 1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic status_check;
    rd_any = ~rd_any;
    // shadow moves only while the link clocks: first read flushes a stale snapshot
    u_fsr_host_model.frame(8'h05, 8'h00, 1'b1, rd);
    repeat (6) @(posedge CORE_CLK);
    u_fsr_host_model.frame(rd_any ? 8'h65 : 8'h05, 8'h00, 1'b1, rd);
    check(rd, {NV_BITS.lock, m_perr, m_eerr, m_bp, m_wel, m_perr | m_eerr | (m_run != 0)});
    check(PROT_LEVEL, m_bp);
    check(n_start, m_start);
    repeat (6) @(posedge CORE_CLK);
  endtask

  task automatic send(input logic [7:0] op, input logic [7:0] dat);
    int   kind;
    logic busy;
    kind = 0;
    busy = m_perr | m_eerr | (m_run != 0);
    u_fsr_host_model.frame(op, dat, op == 8'h01 || op == 8'h71, rd);
    if (op == 8'h30 || op == 8'h82)
    begin
      m_perr = 1'b0;
      m_eerr = 1'b0;
    end
    else if (op == 8'hF0)
    begin
      m_perr = 1'b0;
      m_eerr = 1'b0;
      m_run  = 0;
      m_wel  = NV_BITS.wel_default;
    end
    else if ((op == 8'h85 && m_run == 1) || (op == 8'h75 && m_run == 2))
      m_run = 0;
    else if (!busy)
      case (op)
        8'h06: m_wel = 1'b1;
        8'h04: m_wel = 1'b0;
        8'h01, 8'h71:
          if (m_wel && !(NV_BITS.lock && !WP_N))
            if (NV_BITS.bp_volatile)
            begin
              m_bp  = dat[4:2];
              m_wel = 1'b0;
            end
            else
              kind = 4;
        8'h02: kind = m_wel ? 1 : 0;
        8'hD8: kind = m_wel ? 2 : 0;
        8'h60: kind = (m_wel && m_bp == 3'h0) ? 3 : 0;
        default: ;
      endcase
    if (kind != 0)
      m_start++;
    repeat ((kind != 0 && eng_lat < 40) ? eng_lat + 14 : 12) @(posedge CORE_CLK);
    if (kind != 0 && eng_lat > 40)
      m_run = kind;
    else if (kind == 4)
    begin
      m_bp  = dat[4:2];
      m_wel = 1'b0;
    end
    else if (kind != 0 && (eng_fail || ((eng_hit || m_bp != 3'h0) && kind != 3)))
    begin
      m_perr = m_perr | (kind == 1);
      m_eerr = m_eerr | (kind != 1);
    end
    else if (kind != 0)
      m_wel = 1'b0;
    status_check();
  endtask

  task automatic do_reset;
    @(posedge CORE_CLK) SYS_RST <= 1'b1;
    // mid-run reset held well past the synchroniser depth
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    repeat (5) @(posedge CORE_CLK);
    m_perr = 1'b0;
    m_eerr = 1'b0;
    m_run  = 0;
    m_wel  = NV_BITS.wel_default;
    m_bp   = NV_BITS.bp;
    status_check();
  endtask

  task automatic act(input logic [7:0] a);
    @(posedge CORE_CLK);
    case (a)
      8'h00:
        for (int i = 0; i < 4; i++)
        begin
          seed = lfsr(seed);
          send(8'h06, 8'h00);
          send(seed[8] ? 8'h71 : 8'h01, seed[7:0]);
        end
      8'h01: NV_BITS.bp_volatile <= ~NV_BITS.bp_volatile;
      8'h02: eng_hit = 1'b1;
      8'h03: {eng_hit, eng_fail} = 2'b01;
      8'h04: eng_fail = 1'b0;
      8'h05: {NV_BITS.lock, WP_N} <= 2'b10;
      8'h06: WP_N <= 1'b1;
      8'h07: NV_BITS.lock <= 1'b0;
      8'h08: eng_lat = 200;
      8'h09: eng_lat = 4;
      default: do_reset();
    endcase
    repeat (4) @(posedge CORE_CLK);
  endtask

  initial
  begin
    {SYS_RST, WP_N, rd_any, eng_fail, eng_hit} = 5'b11000;
    NV_BITS = '0;
    ENG_STAT = '0;
    {n_mismatch, cmp_count, n_start, m_start, m_run} = '0;
    eng_lat = 4;
    seed = 32'h6e5a;
    repeat (2) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    // script of opcode and data; FF selects a bench action instead
    foreach (scr[i])
      if (scr[i][15:8] == 8'hFF)
        act(scr[i][7:0]);
      else
        send(scr[i][15:8], scr[i][7:0]);
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge CORE_CLK);
    n_mismatch++;
    print_verdict();
  end
endmodule // fsr_status1_top_test
`default_nettype wire
